//--- hw/wdp_defines.vh
// Constants for the watchdog, power and reset control block
`ifndef WDP_DEFINES_VH
`define WDP_DEFINES_VH
// Register offsets
`define WDP_ADDR_WDCTL 4'h0
`define WDP_ADDR_PWR 4'h1
`define WDP_ADDR_STAT 4'h2
`define WDP_ADDR_MASK 4'h3
`define WDP_ADDR_WDCNT 4'h4
`define WDP_ADDR_SP 4'h5
`define WDP_ADDR_PORT 4'h6
// Watchdog control field positions
`define WDP_WD_RUN 7
`define WDP_WD_KICK 6
`define WDP_WD_IDLE 3
`define WDP_WD_PS_HI 2
// Power control field positions
`define WDP_PWR_IDLE 0
`define WDP_PWR_PDOWN 1
`define WDP_PWR_KEEP 4
// Status bits
`define WDP_ST_WDT 0
`define WDP_ST_WAKE 1
// Reset values
`define WDP_RST_ZERO 8'h00
`define WDP_RST_SP 8'h07
`define WDP_RST_PORT 8'hff
// Timing
`define WDP_OSC_PER_MC 12
`define WDP_SYS_PER_MC 6
`define WDP_CNT_BITS 14
`define WDP_RST_MC 2
`endif

//--- hw/wdp_prescale.v
// Watchdog prescaler: counts machine cycles, pulses at the selected ratio
`timescale 1ns/1ps
`default_nettype none
module wdp_prescale (
   input wire sys_clk,
   input wire clear,
   input wire step,
   input wire [2:0] sel,
   output reg tick_q
);
   reg [7:0] cnt_q;
   reg [7:0] lim;
   // -----------------------------
   // Ratio decode
   // -----------------------------
   always @* begin
      case (sel)
         3'h0: lim = 8'h01;
         3'h2: lim = 8'h03;
         3'h1: lim = 8'h07;
         3'h3: lim = 8'h0f;
         3'h4: lim = 8'h1f;
         3'h5: lim = 8'h3f;
         3'h6: lim = 8'h7f;
         default: lim = 8'hff;
      endcase
   end
   always @(posedge sys_clk) begin
      if (clear) begin
         cnt_q <= 8'h00;
         tick_q <= 1'b0;
      end else begin
         tick_q <= step && (cnt_q == lim);
         if (step)
            cnt_q <= (cnt_q == lim) ? 8'h00 : cnt_q + 8'h01;
      end
   end
endmodule
`default_nettype wire

//--- hw/wdp_sync.v
// Two-flop synchroniser with a two-sample agreement glitch filter on the synced level
`timescale 1ns/1ps
`default_nettype none
module wdp_sync #(
   parameter W = 9
) (
   input wire sys_clk,
   input wire [W-1:0] async_in,
   output reg [W-1:0] sync_q,
   output reg [W-1:0] filt_q
);
   reg [W-1:0] meta_q;
   reg [W-1:0] hist_q;
   genvar i;
   always @(posedge sys_clk) begin
      meta_q <= async_in;
      sync_q <= meta_q;
      hist_q <= sync_q;
   end
   // -----------------------------
   // Filter: level changes only when two samples agree
   // -----------------------------
   generate
      for (i = 0; i < W; i = i + 1) begin : g_filt
         always @(posedge sys_clk) begin
            if (sync_q[i] == hist_q[i])
               filt_q[i] <= sync_q[i];
         end
      end
   endgenerate
endmodule
`default_nettype wire

//--- hw/wdp_top.v
// Watchdog, power mode and reset control
//
// Behaviour
// RL1: Any reset disables the watchdog and clears its counter.
// RL2: Watchdog counts only while the run bit is one.
// RL3: Writing kick clears counter and prescaler; kick bit self-clears.
// RL4: Kick at bit 6; counter, prescaler, kick zero on next machine cycle.
// RL5: Idle-run bit one keeps watchdog counting in idle; resets to zero.
// RL6: Select 000,010,001,011,100..111 give ratios 2,4,8,16,32,64,128,256.
// RL7: Time-out equals 2^14 times ratio times twelve oscillator periods.
// RL8: Time-out while enabled raises a full system reset.
// RL9: Software must kick before each time-out while enabled.
// RL10: Oscillator clock divided by two before internal logic uses it.
// RL11: Idle request stops core clock; peripherals and interrupts keep clock.
// RL12: Interrupt or reset ends idle and restarts core clock.
// RL13: Power-down request stops every clock, oscillator included.
// RL14: Power-down ends only on hardware reset or enabled lines two to nine.
// RL15: Reset pin sampled at state5_phase2; must stay high two machine cycles.
// RL16: Short glitches on the reset pin are filtered out.
// RL17: Reset sets ports FFH, stack 07H, power control 00H except bit 4.
// RL18: Prescaler counts machine cycles; each tick advances counter; overflow times out.
// RL19: Watchdog reset acts exactly like an external reset.
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "wdp_defines.vh"
module wdp_top #(
   parameter CNT_W = `WDP_CNT_BITS
) (
   input wire sys_clk,
   input wire reset,
   input wire reset_pin,
   input wire [7:0] ext_irq_line,
   input wire irq_pending,
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata_q,
   output reg sys_reset_q,
   output reg core_clk_en_q,
   output reg periph_clk_en_q,
   output reg osc_en_q,
   output reg int_q
);
   // -----------------------------
   // Declarations
   // -----------------------------
   reg [7:0] wdctl_q;
   reg [7:0] pwr_q;
   reg [7:0] stat_q;
   reg [7:0] mask_q;
   reg [7:0] sp_q;
   reg [7:0] port_q;
   reg [CNT_W-1:0] cnt_q;
   reg half_q;
   reg [2:0] phase_q;
   reg [2:0] rst_mc_q;
   reg pin_rst_q;
   reg kick_pend_q;
   reg wdt_fire_q;
   reg [7:0] stat_d;
   wire [8:0] sync_lvl;
   wire [8:0] filt_lvl;
   wire mc_step;
   wire pre_tick;
   wire any_rst;
   wire wd_active;
   wire wake_irq;
   wire pd_mode;
   wire idle_mode;
   wire [CNT_W+7:0] cnt_pad;

   function sel_wr;
      input [3:0] a;
      input [3:0] want;
      input wr;
      begin
         sel_wr = wr && (a == want);
      end
   endfunction

   // -----------------------------
   // Clock divide and machine cycle
   // -----------------------------
   // Half-rate enable makes timing independent of input duty cycle
   always @(posedge sys_clk) begin
      if (reset) begin
         half_q <= 1'b0;
         phase_q <= 3'h0;
      end else begin
         half_q <= ~half_q; // [RL10]
         if (half_q)
            phase_q <= (phase_q == 3'h5) ? 3'h0 : phase_q + 3'h1;
      end
   end
   // One machine cycle is six internal states of two oscillator periods
   assign mc_step = half_q && (phase_q == 3'h5) && osc_en_q; // [RL18]

   // -----------------------------
   // Reset pin sampling
   // -----------------------------
   wdp_sync #(.W(9)) u_sync (
      .sys_clk(sys_clk),
      .async_in({reset_pin, ext_irq_line}),
      .sync_q(sync_lvl),
      .filt_q(filt_lvl)
   );
   // Sample filtered pin at state5_phase2, count held machine cycles
   always @(posedge sys_clk) begin
      if (reset) begin
         rst_mc_q <= 3'h0;
         pin_rst_q <= 1'b0;
      end else if (!osc_en_q && filt_lvl[8]) begin
         pin_rst_q <= 1'b1; // [RL14]
      end else if (half_q && phase_q == 3'h4) begin // [RL15]
         if (filt_lvl[8]) begin // [RL16]
            if (rst_mc_q != 3'h7)
               rst_mc_q <= rst_mc_q + 3'h1;
            pin_rst_q <= (rst_mc_q >= 3'h1); // [RL15]
         end else begin
            rst_mc_q <= 3'h0;
            pin_rst_q <= 1'b0;
         end
      end
   end
   assign any_rst = reset || pin_rst_q || wdt_fire_q; // [RL19]

   // -----------------------------
   // Watchdog
   // -----------------------------
   assign idle_mode = pwr_q[`WDP_PWR_IDLE];
   assign pd_mode = pwr_q[`WDP_PWR_PDOWN];
   assign wd_active = wdctl_q[`WDP_WD_RUN] && (!idle_mode || wdctl_q[`WDP_WD_IDLE]) && !pd_mode; // [RL2] [RL5]

   wdp_prescale u_pre (
      .sys_clk(sys_clk),
      .clear(any_rst || kick_pend_q), // [RL3]
      .step(mc_step && wd_active),
      .sel(wdctl_q[`WDP_WD_PS_HI:0]), // [RL6]
      .tick_q(pre_tick)
   );

   always @(posedge sys_clk) begin
      if (any_rst) begin
         cnt_q <= {CNT_W{1'b0}}; // [RL1]
         wdt_fire_q <= 1'b0;
         kick_pend_q <= 1'b0;
      end else begin
         wdt_fire_q <= 1'b0;
         if (sel_wr(reg_addr, `WDP_ADDR_WDCTL, reg_wr) && reg_wdata[`WDP_WD_KICK])
            kick_pend_q <= 1'b1;
         else if (mc_step)
            kick_pend_q <= 1'b0; // [RL4]
         if (kick_pend_q && mc_step) begin
            cnt_q <= {CNT_W{1'b0}}; // [RL3] [RL4]
         end else if (pre_tick && wd_active) begin
            cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1}; // [RL7] [RL18]
            if (&cnt_q)
               wdt_fire_q <= 1'b1; // [RL8]
         end
      end
   end

   // -----------------------------
   // Registers and power modes
   // -----------------------------
   assign wake_irq = |(filt_lvl[7:0] & mask_q); // [RL14]

   always @* begin
      stat_d = stat_q;
      if (sel_wr(reg_addr, `WDP_ADDR_STAT, reg_wr))
         stat_d = stat_q & ~reg_wdata;
      if (wdt_fire_q)
         stat_d[`WDP_ST_WDT] = 1'b1;
      if (pd_mode && wake_irq)
         stat_d[`WDP_ST_WAKE] = 1'b1;
   end

   always @(posedge sys_clk) begin
      if (reset) begin
         stat_q <= `WDP_RST_ZERO;
      end else begin
         stat_q <= stat_d;
      end
   end

   always @(posedge sys_clk) begin
      if (any_rst) begin
         wdctl_q <= `WDP_RST_ZERO; // [RL1] [RL17]
         pwr_q <= {3'h0, pwr_q[`WDP_PWR_KEEP], 4'h0}; // [RL17]
         mask_q <= `WDP_RST_ZERO;
         sp_q <= `WDP_RST_SP; // [RL17]
         port_q <= `WDP_RST_PORT; // [RL17]
      end else begin
         if (mc_step && kick_pend_q)
            wdctl_q[`WDP_WD_KICK] <= 1'b0; // [RL3]
         if (sel_wr(reg_addr, `WDP_ADDR_WDCTL, reg_wr))
            wdctl_q <= reg_wdata & 8'hcf;
         if (sel_wr(reg_addr, `WDP_ADDR_PWR, reg_wr))
            pwr_q <= reg_wdata;
         else if (idle_mode && irq_pending)
            pwr_q[`WDP_PWR_IDLE] <= 1'b0; // [RL12]
         else if (pd_mode && wake_irq)
            pwr_q[`WDP_PWR_PDOWN] <= 1'b0; // [RL14]
         if (sel_wr(reg_addr, `WDP_ADDR_MASK, reg_wr))
            mask_q <= reg_wdata;
         if (sel_wr(reg_addr, `WDP_ADDR_SP, reg_wr))
            sp_q <= reg_wdata;
         if (sel_wr(reg_addr, `WDP_ADDR_PORT, reg_wr))
            port_q <= reg_wdata;
      end
   end

   // -----------------------------
   // Outputs
   // -----------------------------
   // Counter padded below so any width yields its top eight bits
   assign cnt_pad = {cnt_q, 8'h00};
   always @(posedge sys_clk) begin
      if (reset) begin
         sys_reset_q <= 1'b1;
         core_clk_en_q <= 1'b0;
         periph_clk_en_q <= 1'b0;
         osc_en_q <= 1'b1;
         int_q <= 1'b0;
         reg_rdata_q <= 8'h00;
      end else begin
         sys_reset_q <= pin_rst_q || wdt_fire_q; // [RL8] [RL19]
         core_clk_en_q <= half_q && !idle_mode && !pd_mode; // [RL10] [RL11] [RL12]
         periph_clk_en_q <= half_q && !pd_mode; // [RL11] [RL13]
         osc_en_q <= !pd_mode; // [RL13]
         int_q <= |(stat_d & mask_q);
         reg_rdata_q <= 8'h00;
         if (reg_rd) begin
            case (reg_addr)
               `WDP_ADDR_WDCTL: reg_rdata_q <= wdctl_q;
               `WDP_ADDR_PWR: reg_rdata_q <= pwr_q;
               `WDP_ADDR_STAT: reg_rdata_q <= stat_q;
               `WDP_ADDR_MASK: reg_rdata_q <= mask_q;
               `WDP_ADDR_WDCNT: reg_rdata_q <= cnt_pad[CNT_W+7:CNT_W];
               `WDP_ADDR_SP: reg_rdata_q <= sp_q;
               `WDP_ADDR_PORT: reg_rdata_q <= port_q;
               default: reg_rdata_q <= 8'h00;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking testbench for the watchdog, power and reset block
`timescale 1ns/1ps
`default_nettype none
`include "wdp_defines.vh"
module tb_top;
   localparam int TO_BASE = (1 << 4) * 12;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic reset_pin = 1'b0;
   logic [7:0] ext_irq_line = 8'h00;
   logic irq_pending = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   wire logic [7:0] reg_rdata_q;
   wire logic sys_reset_q, core_clk_en_q, periph_clk_en_q, osc_en_q, int_q;
   logic [2:0] sel_tab [4] = '{3'h0, 3'h2, 3'h1, 3'h3};
   int num_errors = 0;
   int total_checks = 0;
   int rst_n = 0;
   int core_n = 0;
   int per_n = 0;
   int n, m, r;
   wdp_top #(.CNT_W(4)) wdp_top_inst (.sys_clk, .reset, .reset_pin, .ext_irq_line, .irq_pending, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .sys_reset_q, .core_clk_en_q, .periph_clk_en_q, .osc_en_q, .int_q);
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      rst_n <= rst_n + int'(sys_reset_q && !reset);
      core_n <= core_n + int'(core_clk_en_q);
      per_n <= per_n + int'(periph_clk_en_q);
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata_q, e);
      @(posedge sys_clk);
   endtask
   task automatic st(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask
   task automatic wait_rst(input int lim);
      n = 0;
      while (sys_reset_q !== 1'b1 && n < lim) begin
         st(1);
         n++;
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      st(3);
      reset <= 1'b0;
      st(1);
      rdc(`WDP_ADDR_WDCTL, 8'h00);
      rdc(`WDP_ADDR_PWR, 8'h00);
      rdc(`WDP_ADDR_SP, 8'h07);
      rdc(`WDP_ADDR_PORT, 8'hff);
      rdc(`WDP_ADDR_WDCNT, 8'h00);
      rdc(4'hf, 8'h00);
      $display("reset values done");
      for (int i = 0; i < 4; i++) begin
         wr(`WDP_ADDR_WDCTL, {5'h10, sel_tab[i]});
         wait_rst(5000);
         r = (2 << i) * TO_BASE;
         chk(8'(n > r - 16 && n < r + 16), 8'h01);
         st(4);
         rdc(`WDP_ADDR_WDCTL, 8'h00);
         rdc(`WDP_ADDR_STAT, 8'h01);
      end
      wr(`WDP_ADDR_MASK, 8'h01);
      st(1);
      chk(int_q, 1'b1);
      wr(`WDP_ADDR_STAT, 8'h01);
      st(1);
      chk(int_q, 1'b0);
      $display("time-out done");
      r = rst_n;
      wr(`WDP_ADDR_WDCTL, 8'h80);
      repeat (5) begin
         st(300);
         wr(`WDP_ADDR_WDCTL, 8'hc0);
      end
      st(14);
      rdc(`WDP_ADDR_WDCTL, 8'h80);
      wr(`WDP_ADDR_WDCTL, 8'h00);
      st(500);
      chk(8'(rst_n - r), 8'h00);
      $display("kick done");
      wr(`WDP_ADDR_WDCTL, 8'hc0);
      wr(`WDP_ADDR_PWR, 8'h01);
      st(4);
      n = core_n;
      m = per_n;
      st(500);
      chk(8'(core_n - n), 8'h00);
      chk(8'(per_n - m > 200), 8'h01);
      chk(8'(rst_n - r), 8'h00);
      irq_pending <= 1'b1;
      st(4);
      irq_pending <= 1'b0;
      st(4);
      chk(8'(core_n - n > 0), 8'h01);
      rdc(`WDP_ADDR_PWR, 8'h00);
      wr(`WDP_ADDR_WDCTL, 8'hc8);
      wr(`WDP_ADDR_PWR, 8'h01);
      wait_rst(600);
      chk(8'(n < 600), 8'h01);
      st(4);
      rdc(`WDP_ADDR_PWR, 8'h00);
      $display("idle done");
      r = rst_n;
      reset_pin <= 1'b1;
      st(1);
      reset_pin <= 1'b0;
      st(20);
      chk(8'(rst_n - r), 8'h00);
      wr(`WDP_ADDR_STAT, 8'hff);
      wr(`WDP_ADDR_MASK, 8'hff);
      wr(`WDP_ADDR_PWR, 8'h02);
      st(20);
      m = per_n;
      st(20);
      chk(osc_en_q, 1'b0);
      chk(8'(per_n - m), 8'h00);
      ext_irq_line <= 8'h80;
      st(20);
      ext_irq_line <= 8'h00;
      chk(osc_en_q, 1'b1);
      rdc(`WDP_ADDR_STAT, 8'h02);
      wr(`WDP_ADDR_MASK, 8'h00);
      wr(`WDP_ADDR_PWR, 8'h02);
      st(10);
      ext_irq_line <= 8'h01;
      st(20);
      chk(osc_en_q, 1'b0);
      ext_irq_line <= 8'h00;
      reset_pin <= 1'b1;
      st(40);
      reset_pin <= 1'b0;
      st(10);
      chk(osc_en_q, 1'b1);
      rdc(`WDP_ADDR_SP, 8'h07);
      $display("power-down done");
      wrap_up();
   end
   initial begin
      #300000;
      num_errors++;
      wrap_up();
   end
endmodule
`default_nettype wire

//--- verif/wdp_chk.sv
// Assertion checker for the watchdog, power and reset block
`timescale 1ns/1ps
`default_nettype none
`include "wdp_defines.vh"
module wdp_chk (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic reset_pin,
   input wire logic [7:0] ext_irq_line,
   input wire logic irq_pending,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic sys_reset_q,
   input wire logic core_clk_en_q,
   input wire logic periph_clk_en_q,
   input wire logic osc_en_q,
   input wire logic int_q
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   sequence s_quiet;
      (!reset_pin && ext_irq_line == 8'h00) [*6];
   endsequence
   sequence s_live;
      (osc_en_q && !sys_reset_q) [*3];
   endsequence
   property p_hard_rst;
      $fell(reset) |-> sys_reset_q && osc_en_q && !core_clk_en_q && !int_q;
   endproperty
   a_hard_rst: assert property (p_hard_rst) else $error("reset state wrong");
   property p_core_div;
      core_clk_en_q |=> !core_clk_en_q;
   endproperty
   a_core_div: assert property (p_core_div) else $error("core enable too fast");
   property p_per_run;
      s_live ##0 !periph_clk_en_q ##1 (osc_en_q && !sys_reset_q) |-> periph_clk_en_q;
   endproperty
   a_per_run: assert property (p_per_run) else $error("peripheral clock stalled");
   property p_wake_irq;
      s_live ##0 irq_pending |-> ##[1:4] core_clk_en_q;
   endproperty
   a_wake_irq: assert property (p_wake_irq) else $error("core not resumed");
   property p_pd_gate;
      !osc_en_q [*2] |-> !core_clk_en_q && !periph_clk_en_q;
   endproperty
   a_pd_gate: assert property (p_pd_gate) else $error("clock in power-down");
   property p_pd_enter;
      s_quiet ##0 (reg_wr && reg_addr == `WDP_ADDR_PWR && reg_wdata[1] && !sys_reset_q) |-> ##[1:12] !osc_en_q;
   endproperty
   a_pd_enter: assert property (p_pd_enter) else $error("no power-down");
   property p_pd_stay;
      s_quiet ##0 !osc_en_q |=> !osc_en_q;
   endproperty
   a_pd_stay: assert property (p_pd_stay) else $error("spurious wake");
   property p_pin_hold;
      $rose(reset_pin) && !sys_reset_q |=> !sys_reset_q [*3];
   endproperty
   a_pin_hold: assert property (p_pin_hold) else $error("pin reset too early");
endmodule
bind wdp_top wdp_chk wdp_chk_inst (.sys_clk, .reset, .reset_pin, .ext_irq_line, .irq_pending, .reg_addr,
   .reg_wdata, .reg_wr, .sys_reset_q, .core_clk_en_q, .periph_clk_en_q, .osc_en_q, .int_q);
`default_nettype wire
